/* eac_consts.svh */
// Register offsets, field positions, reset values and timing counts of the EEPROM access controller.
`ifndef EAC_CONSTS_SVH
`define EAC_CONSTS_SVH
`define EAC_OFF_CONTROL 6'h1c
`define EAC_OFF_DATA 6'h1d
`define EAC_OFF_ADDR_LOW 6'h1e
`define EAC_OFF_ADDR_HIGH 6'h1f
`define EAC_BIT_READ 0
`define EAC_BIT_WRITE 1
`define EAC_BIT_ARM 2
`define EAC_BIT_RDY_IE 3
`define EAC_RST_CONTROL 8'h00
`define EAC_RST_DATA 8'h00
`define EAC_ARM_CYCLES 3'h4
`define EAC_WRITE_STALL 3'h2
`define EAC_READ_STALL 3'h4
`define EAC_WRITE_OSC_CYCLES 14'h2100
`define EAC_OSC_MHZ 1
`define EAC_CLK_MHZ 20
`define EAC_TICK_DIV 5'h14
`endif

/* eac_controller.sv */
// EEPROM access controller: I/O registers, write timing, read path and CPU halt.
// Function
// - Address from low byte and three high bits.
// - Address maps linearly onto the array.
// - Address registers have no reset value.
// - Data register feeds writes, holds read bytes.
// - Bit 3 enables ready request with global enable.
// - Ready request stays high while strobe low.
// - Armed write strobe within four cycles programs.
// - Unarmed write strobe does nothing.
// - Arm bit clears itself after four cycles.
// - Write strobe stays set until programming ends.
// - Write start halts CPU for two cycles.
// - Read strobe fetches byte into data register.
// - Read halts CPU for four cycles.
// - During write, reads ignored, address frozen.
// - Write lasts 8448 ticks of 1 MHz.
`timescale 1ns/100ps
`default_nettype none
`include "eac_consts.svh"
module eac_controller
	import eac_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic [5:0] io_addr,
	input wire logic io_wr,
	input wire logic io_rd,
	input wire logic [7:0] io_wdata,
	output logic [7:0] io_rdata,
	input wire logic global_irq_enable,
	input wire logic self_program_busy,
	output logic ready_irq,
	output logic cpu_halt,
	output logic write_busy
);
	// ==========================================================
	// Storage and registers
	// ==========================================================
	logic [7:0] mem [0:2047];
	logic [7:0] nv_addr_low_reg;
	logic [2:0] nv_addr_high_reg;
	logic [7:0] data_ff;
	logic ready_irq_enable_ff;
	logic master_write_arm_ff;
	logic write_strobe_ff;
	logic read_strobe_ff;
	logic [2:0] arm_count_ff;
	logic [4:0] tick_div_ff;
	logic [13:0] osc_count_ff;
	logic [10:0] wr_addr_ff;
	logic [7:0] wr_data_ff;
	eac_state_type state_ff;
	logic [10:0] nv_addr_reg;
	logic ctl_wr;
	logic start_write;
	logic start_read;
	logic write_done;
	logic stall_load;
	logic [2:0] stall_cycles;
	logic stall_busy;

	assign nv_addr_reg = {nv_addr_high_reg, nv_addr_low_reg};
	assign ctl_wr = io_wr && (io_addr == `EAC_OFF_CONTROL);
	assign start_write = ctl_wr && io_wdata[`EAC_BIT_WRITE] && master_write_arm_ff
		&& !write_strobe_ff;
	assign start_read = ctl_wr && io_wdata[`EAC_BIT_READ] && !write_strobe_ff;
	assign write_done = (state_ff == eac_writing) && (osc_count_ff == 14'h0)
		&& (tick_div_ff == 5'h0);

	// ==========================================================
	// Address registers
	// ==========================================================
	// No reset on purpose: software must load the address before use.
	// Address left uninitialised.
	always_ff @(posedge clk) begin
		if (io_wr && !write_strobe_ff) begin
			if (io_addr == `EAC_OFF_ADDR_LOW) begin
				nv_addr_low_reg <= io_wdata;
			end
			if (io_addr == `EAC_OFF_ADDR_HIGH) begin
				nv_addr_high_reg <= io_wdata[2:0];
			end
		end
	end

	// ==========================================================
	// Data register
	// ==========================================================
	// A read fetch takes precedence over a same-cycle bus write to data.
	// Data register load.
	always_ff @(posedge clk) begin
		if (rst) begin
			data_ff <= `EAC_RST_DATA;
		end else if (start_read) begin
			data_ff <= mem[nv_addr_reg];
		end else if (io_wr && (io_addr == `EAC_OFF_DATA)) begin
			data_ff <= io_wdata;
		end
	end

	// ==========================================================
	// Control bits
	// ==========================================================
	// Ready interrupt enable bit.
	always_ff @(posedge clk) begin
		if (rst) begin
			ready_irq_enable_ff <= 1'b0;
		end else if (ctl_wr) begin
			ready_irq_enable_ff <= io_wdata[`EAC_BIT_RDY_IE];
		end
	end

	// Arming only counts when the strobe is written zero in the same access.
	// Arm self-clear after four.
	always_ff @(posedge clk) begin
		if (rst) begin
			master_write_arm_ff <= 1'b0;
			arm_count_ff <= 3'h0;
		end else if (ctl_wr && io_wdata[`EAC_BIT_ARM] && !io_wdata[`EAC_BIT_WRITE]) begin
			master_write_arm_ff <= 1'b1;
			arm_count_ff <= `EAC_ARM_CYCLES;
		end else if (master_write_arm_ff) begin
			if (arm_count_ff == 3'h1 || start_write) begin
				master_write_arm_ff <= 1'b0;
				arm_count_ff <= 3'h0;
			end else begin
				arm_count_ff <= arm_count_ff - 3'h1;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			read_strobe_ff <= 1'b0;
		end else begin
			read_strobe_ff <= start_read;
		end
	end

	// ==========================================================
	// Write sequencer
	// ==========================================================
	// The 1 MHz tick is derived from the CPU clock so one clock domain suffices.
	// Timed write duration.
	always_ff @(posedge clk) begin
		if (rst) begin
			state_ff <= eac_idle;
			write_strobe_ff <= 1'b0;
			tick_div_ff <= 5'h0;
			osc_count_ff <= 14'h0;
			wr_addr_ff <= 11'h0;
			wr_data_ff <= 8'h0;
		end else begin
			unique case (state_ff)
				eac_idle: begin
					if (start_write) begin
						state_ff <= eac_writing;
						write_strobe_ff <= 1'b1;
						wr_addr_ff <= nv_addr_reg;
						wr_data_ff <= data_ff;
						tick_div_ff <= `EAC_TICK_DIV - 5'h1;
						osc_count_ff <= `EAC_WRITE_OSC_CYCLES - 14'h1;
					end
				end
				eac_writing: begin
					if (write_done) begin
						state_ff <= eac_finish;
					end else if (tick_div_ff == 5'h0) begin
						tick_div_ff <= `EAC_TICK_DIV - 5'h1;
						osc_count_ff <= osc_count_ff - 14'h1;
					end else begin
						tick_div_ff <= tick_div_ff - 5'h1;
					end
				end
				eac_finish: begin
					state_ff <= eac_idle;
					write_strobe_ff <= 1'b0;
				end
				// The fourth code of the state word is unused; fall back to idle.
				default: begin
					state_ff <= eac_idle;
					write_strobe_ff <= 1'b0;
				end
			endcase
		end
	end

	// The array cell is committed as the timed interval ends.
	always_ff @(posedge clk) begin
		if (state_ff == eac_finish) begin
			mem[wr_addr_ff] <= wr_data_ff;
		end
	end

	// ==========================================================
	// Write length check
	// ==========================================================
	// The strobe stands far too long for a repetition, so a helper counter measures it.
	// The bound is built from the tick count, never from the sequencer's own counters.
	localparam logic [17:0] WRITE_CLKS = 18'(`EAC_WRITE_OSC_CYCLES) * 18'(`EAC_TICK_DIV);
	logic [17:0] strobe_len_ff;

	// Cycles with the write strobe set since it rose.
	always_ff @(posedge clk) begin
		if (rst || !write_strobe_ff) begin
			strobe_len_ff <= 18'h0;
		end else begin
			strobe_len_ff <= strobe_len_ff + 18'h1;
		end
	end

	a_write_length: assert property (@(posedge clk) disable iff (rst)
		$fell(write_strobe_ff) |-> (strobe_len_ff >= WRITE_CLKS)
		&& (strobe_len_ff <= WRITE_CLKS + 18'h2))
		else $error("write interval length wrong");

	// ==========================================================
	// CPU halt
	// ==========================================================
	// Two-cycle halt on write.
	assign stall_load = start_write || start_read;
	assign stall_cycles = start_write ? `EAC_WRITE_STALL : `EAC_READ_STALL;

	eac_stall_timer u_stall (
		.clk(clk),
		.rst(rst),
		.load(stall_load),
		.cycles(stall_cycles),
		.busy(stall_busy)
	);

	assign cpu_halt = stall_busy;
	assign write_busy = write_strobe_ff;

	assign ready_irq = ready_irq_enable_ff && global_irq_enable && !write_strobe_ff;

	// ==========================================================
	// Read-back
	// ==========================================================
	always_comb begin
		io_rdata = 8'h00;
		if (io_rd) begin
			unique case (io_addr)
				`EAC_OFF_CONTROL: io_rdata = {4'h0, ready_irq_enable_ff, master_write_arm_ff,
					write_strobe_ff, read_strobe_ff};
				`EAC_OFF_DATA: io_rdata = data_ff;
				`EAC_OFF_ADDR_LOW: io_rdata = nv_addr_low_reg;
				`EAC_OFF_ADDR_HIGH: io_rdata = {5'h0, nv_addr_high_reg};
				default: io_rdata = 8'h00;
			endcase
		end
	end

	// ==========================================================
	// Checks
	// ==========================================================
	a_arm_clears: assert property (@(posedge clk) disable iff (rst)
		(ctl_wr && io_wdata[`EAC_BIT_ARM] && !io_wdata[`EAC_BIT_WRITE])
		|=> master_write_arm_ff ##4 !master_write_arm_ff)
		else $error("arm bit did not clear after four cycles");
	a_unarmed_write: assert property (@(posedge clk) disable iff (rst)
		(ctl_wr && io_wdata[`EAC_BIT_WRITE] && !master_write_arm_ff && !write_strobe_ff)
		|=> !write_strobe_ff)
		else $error("write started without arm");
	a_armed_write: assert property (@(posedge clk) disable iff (rst)
		start_write |=> write_strobe_ff)
		else $error("armed write did not start");
	a_write_hold: assert property (@(posedge clk) disable iff (rst)
		$rose(write_strobe_ff) |-> write_strobe_ff [*8])
		else $error("write strobe dropped early");
	a_write_stall: assert property (@(posedge clk) disable iff (rst)
		start_write |=> cpu_halt ##1 cpu_halt ##1 !cpu_halt)
		else $error("write halt not two cycles");
	a_read_stall: assert property (@(posedge clk) disable iff (rst)
		start_read |=> cpu_halt [*4] ##1 !cpu_halt)
		else $error("read halt not four cycles");
	a_read_fetch: assert property (@(posedge clk) disable iff (rst)
		start_read |=> data_ff == mem[$past(nv_addr_reg)])
		else $error("read byte not fetched");
	a_addr_frozen: assert property (@(posedge clk) disable iff (rst)
		write_strobe_ff |=> $stable(nv_addr_reg) || !$past(write_strobe_ff))
		else $error("address changed during write");
	a_ready_level: assert property (@(posedge clk) disable iff (rst)
		(ready_irq_enable_ff && global_irq_enable && !write_strobe_ff) |-> ready_irq)
		else $error("ready request missing");
	a_read_pulse: assert property (@(posedge clk) disable iff (rst)
		read_strobe_ff |=> !read_strobe_ff || $past(start_read))
		else $error("read strobe stuck");
	a_read_blocked: assert property (@(posedge clk) disable iff (rst)
		(write_strobe_ff && ctl_wr && io_wdata[`EAC_BIT_READ]) |=> !read_strobe_ff)
		else $error("read started during write");
	a_ready_quiet: assert property (@(posedge clk) disable iff (rst)
		write_strobe_ff |-> !ready_irq)
		else $error("ready request during write");
endmodule // eac_controller
`default_nettype wire

/* eac_controller_tb.sv */
// Self-checking testbench for the EEPROM access controller.
`timescale 1ns/100ps
`default_nettype none
`include "eac_consts.svh"
module testbench
	import eac_pkg::*;
;
	localparam int WR_CYC = `EAC_WRITE_OSC_CYCLES * `EAC_TICK_DIV;
	// The ceiling covers one full write plus the short register tests around it.
	localparam int LIMIT = WR_CYC + 3000;
	logic clk, rst, io_wr, io_rd, gie, spb, ready_irq, cpu_halt, write_busy, ie, g;
	logic [5:0] io_addr;
	logic [7:0] io_wdata, io_rdata, v, d, lo, hi;
	int cyc, t0, dt, errors, cmp_count;
	integer seed;

	eac_controller i_eac_controller (.clk(clk), .rst(rst), .io_addr(io_addr), .io_wr(io_wr),
		.io_rd(io_rd), .io_wdata(io_wdata), .io_rdata(io_rdata), .global_irq_enable(gie),
		.self_program_busy(spb), .ready_irq(ready_irq), .cpu_halt(cpu_halt),
		.write_busy(write_busy));

	// ==========================================
	// Expectation functions and bus tasks
	function automatic logic [7:0] ctl_word(input logic rie, arm, wr, rd);
		return {4'h0, rie, arm, wr, rd};
	endfunction
	function automatic logic exp_irq(input logic rie, ge, busy);
		return rie & ge & ~busy;
	endfunction
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			errors++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	// Each access waits for an edge first, so two calls never touch io_wr in one step.
	task automatic io_write(input logic [5:0] a, input logic [7:0] dat);
		@(posedge clk);
		#1;
		io_addr = a;
		io_wdata = dat;
		io_wr = 1'b1;
		@(posedge clk);
		#1;
		io_wr = 1'b0;
	endtask
	task automatic check_read(input logic [5:0] a, input logic [7:0] exp);
		@(posedge clk);
		#1;
		io_addr = a;
		io_rd = 1'b1;
		#10;
		chk(io_rdata, exp);
		@(posedge clk);
		#1;
		io_rd = 1'b0;
	endtask
	task automatic wrap_up();
		$display("comparisons %0d mismatches %0d", cmp_count, errors);
		if (errors == 0 && cmp_count > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	// ==========================================
	// Clock and hang guard
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == LIMIT) begin
			errors++;
			wrap_up();
		end
	end

	// ==========================================
	// Main sequence
	// Self-programming stays idle (spb low) for the whole run.
	initial begin
		{rst, io_wr, io_rd, gie, spb} = 5'h10;
		io_addr = 6'h00;
		io_wdata = 8'h00;
		{errors, cmp_count} = '0;
		seed = 32'hd63f;
		repeat (20) @(posedge clk);
		#1;
		rst = 1'b0;
		check_read(`EAC_OFF_CONTROL, `EAC_RST_CONTROL);
		check_read(`EAC_OFF_DATA, `EAC_RST_DATA);
		check_read(6'h10, 8'h00);
		chk({6'h0, write_busy, cpu_halt}, 8'h00);
		$display("test reset values done");
		// Every enable pair, then two random pairs.
		for (int i = 0; i < 6; i++) begin
			{ie, g} = (i < 4) ? i[1:0] : 2'($random(seed));
			gie = g;
			io_write(`EAC_OFF_CONTROL, ctl_word(ie, 1'b0, 1'b0, 1'b0));
			chk({7'h0, ready_irq}, {7'h0, exp_irq(ie, g, 1'b0)});
		end
		$display("test ready request done");
		d = 8'($random(seed));
		lo = 8'($random(seed));
		hi = 8'($random(seed));
		io_write(`EAC_OFF_DATA, d);
		check_read(`EAC_OFF_DATA, d);
		io_write(`EAC_OFF_ADDR_LOW, lo);
		io_write(`EAC_OFF_ADDR_HIGH, hi);
		check_read(`EAC_OFF_ADDR_LOW, lo);
		check_read(`EAC_OFF_ADDR_HIGH, {5'h0, hi[2:0]});
		$display("test register access done");
		io_write(`EAC_OFF_CONTROL, ctl_word(1'b0, 1'b0, 1'b1, 1'b0));
		chk({6'h0, write_busy, cpu_halt}, 8'h00);
		io_write(`EAC_OFF_CONTROL, ctl_word(1'b0, 1'b1, 1'b0, 1'b0));
		check_read(`EAC_OFF_CONTROL, ctl_word(1'b0, 1'b1, 1'b0, 1'b0));
		@(posedge clk);
		check_read(`EAC_OFF_CONTROL, 8'h00);
		io_write(`EAC_OFF_CONTROL, ctl_word(1'b0, 1'b0, 1'b1, 1'b0));
		chk({7'h0, write_busy}, 8'h00);
		$display("test arm window done");
		gie = 1'b0;
		chk({7'h0, write_busy}, 8'h00);
		@(posedge clk);
		#1;
		io_addr = `EAC_OFF_CONTROL;
		io_wdata = ctl_word(1'b1, 1'b1, 1'b0, 1'b0);
		io_wr = 1'b1;
		@(posedge clk);
		#1;
		io_wdata = ctl_word(1'b1, 1'b1, 1'b1, 1'b0);
		@(posedge clk);
		#1;
		io_wr = 1'b0;
		// The sequence is over, so interrupts may come back for the ready check.
		gie = 1'b1;
		t0 = cyc;
		chk({6'h0, write_busy, cpu_halt}, 8'h03);
		chk({7'h0, ready_irq}, {7'h0, exp_irq(1'b1, 1'b1, 1'b1)});
		@(posedge clk);
		#1;
		chk({7'h0, cpu_halt}, 8'h01);
		@(posedge clk);
		#1;
		chk({7'h0, cpu_halt}, 8'h00);
		io_write(`EAC_OFF_ADDR_LOW, ~lo);
		check_read(`EAC_OFF_ADDR_LOW, lo);
		io_write(`EAC_OFF_CONTROL, ctl_word(1'b1, 1'b0, 1'b0, 1'b1));
		chk({7'h0, cpu_halt}, 8'h00);
		check_read(`EAC_OFF_CONTROL, ctl_word(1'b1, 1'b0, 1'b1, 1'b0));
		while (write_busy === 1'b1 && cyc < LIMIT) begin
			@(posedge clk);
			#1;
		end
		dt = cyc - t0;
		chk({7'h0, dt >= WR_CYC - 2 && dt <= WR_CYC + 4}, 8'h01);
		chk({7'h0, ready_irq}, {7'h0, exp_irq(1'b1, 1'b1, 1'b0)});
		$display("test timed write done");
		io_write(`EAC_OFF_DATA, ~d);
		io_write(`EAC_OFF_CONTROL, ctl_word(1'b0, 1'b0, 1'b0, 1'b1));
		chk({7'h0, cpu_halt}, 8'h01);
		repeat (3) begin
			@(posedge clk);
			#1;
			chk({7'h0, cpu_halt}, 8'h01);
		end
		@(posedge clk);
		#1;
		chk({7'h0, cpu_halt}, 8'h00);
		check_read(`EAC_OFF_DATA, d);
		check_read(`EAC_OFF_CONTROL, 8'h00);
		$display("test read back done");
		wrap_up();
	end
endmodule // testbench
`default_nettype wire

/* eac_pkg.sv */
// Types shared by the EEPROM access controller files.
package eac_pkg;
	typedef enum logic [1:0] {
		eac_idle,
		eac_writing,
		eac_finish
	} eac_state_type;
endpackage

/* eac_stall_timer.sv */
// Small down-counter that holds the CPU halt for a loaded number of cycles.
`timescale 1ns/100ps
`default_nettype none
`include "eac_consts.svh"
module eac_stall_timer
	import eac_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic load,
	input wire logic [2:0] cycles,
	output logic busy
);
	logic [2:0] count_ff;

	// A new load restarts the count; otherwise count down to zero.
	always_ff @(posedge clk) begin
		if (rst) begin
			count_ff <= 3'h0;
		end else if (load) begin
			count_ff <= cycles;
		end else if (count_ff != 3'h0) begin
			count_ff <= count_ff - 3'h1;
		end
	end

	assign busy = (count_ff != 3'h0);
endmodule // eac_stall_timer
`default_nettype wire
